// *** logic/pvlm_pkg.sv ***
`default_nettype none
package pvlm_pkg;
	// ==============================
	// data and bus widths, channel and limit counts
	localparam int PVLM_DW = 32;
	localparam int PVLM_AW = 8;
	localparam int PVLM_NCH = 3;
	localparam int PVLM_NLIM = 5;
	// ==============================
	// register byte offsets
	localparam logic [7:0] PVLM_LIM_END = 8'h60;
	localparam logic [7:0] PVLM_ADJ_OFS = 8'h60;
	localparam logic [7:0] PVLM_ADJ_FAC = 8'h64;
	localparam logic [7:0] PVLM_CUT_VOL = 8'h68;
	localparam logic [7:0] PVLM_CUT_VEL = 8'h6c;
	localparam logic [7:0] PVLM_CTRL = 8'h70;
	localparam logic [7:0] PVLM_STAT = 8'h74;
	localparam logic [7:0] PVLM_PV_VOL = 8'h78;
	localparam logic [7:0] PVLM_PV_VEL = 8'h7c;
	localparam logic [7:0] PVLM_PV_CON = 8'h80;
	// limit slots inside a channel block of 0x20 bytes
	localparam int PVLM_LIM_UA = 0;
	localparam int PVLM_LIM_UW = 1;
	localparam int PVLM_LIM_LW = 2;
	localparam int PVLM_LIM_LA = 3;
	localparam int PVLM_LIM_HY = 4;
	// ==============================
	// control field positions
	localparam int PVLM_C_FSEN = 0;
	localparam int PVLM_C_MODE = 1;
	localparam int PVLM_C_SEL = 3;
	localparam int PVLM_C_IND = 5;
	localparam int PVLM_C_INS = 6;
	localparam int PVLM_C_MASK = 8;
	localparam int PVLM_MASK_W = 6;
	// status field names; STAT holds alarm 8:6, warn 5:3, insul 2, fail-safe 1, status out 0
	localparam int PVLM_S_ALM = 0;
	localparam int PVLM_S_WRN = 3;
	localparam int PVLM_S_INS = 6;
	localparam int PVLM_S_FS = 7;
	localparam int PVLM_S_SO = 8;
	// ==============================
	// correction factor is q16.16; reset value is 1.0
	localparam int PVLM_FRAC = 16;
	localparam logic [31:0] PVLM_FAC_ONE = 32'h0001_0000;
	localparam logic [31:0] PVLM_CTRL_RST = 32'h0000_0000;
	// ==============================
	// update period
	localparam int PVLM_PERIOD_MS = 10;
	localparam int PVLM_CLK_HZ = 10_000_000;
	localparam int PVLM_TICK_CYC = PVLM_CLK_HZ / 1000 * PVLM_PERIOD_MS;
	// ==============================
	typedef enum logic [1:0] {
		PVLM_OUT_CURRENT,
		PVLM_OUT_PULSE,
		PVLM_OUT_FREQ,
		PVLM_OUT_STATUS
	} pvlm_mode_t;
	typedef enum logic [1:0] {
		PVLM_ST_IDLE,
		PVLM_ST_CORR,
		PVLM_ST_COMP
	} pvlm_state_t;
	typedef struct packed {
		logic valid;
		logic signed [31:0] vol;
		logic signed [31:0] vel;
		logic signed [31:0] cond;
	} pvlm_sample_t;
	typedef struct packed {
		logic [2:0] alarm;
		logic [2:0] warn;
		logic insul_alarm;
		logic fail_safe;
		logic status_out;
	} pvlm_flags_t;
endpackage
`default_nettype wire

// *** logic/pvlm_top.sv ***
// The address map and register access over APB were decided locally.
`default_nettype none
// Functional notes
// [RULE1] A new sample set is processed once every 10 ms, giving 100 Hz updates of all values.
// [RULE2] Each of volume flow, velocity and conductivity has upper/lower alarm and warning limits plus hysteresis.
// [RULE3] A process alarm is raised when a value is above its upper or below its lower alarm limit.
// [RULE4] A process warning is raised when a value is above its upper or below its lower warning limit.
// [RULE5] An active upper alarm clears only when the value drops below the upper limit minus hysteresis.
// [RULE6] An active lower alarm clears only when the value rises above the lower limit plus hysteresis.
// [RULE7] With zero hysteresis an alarm clears as soon as the value crosses back over its limit.
// [RULE8] A lower warning limit of zero on a flow value warns on any negative flow, showing reverse flow.
// [RULE9] Fail-safe is forced only in current, pulse or frequency mode, with fail-safe enabled and an alarm on the selected value.
//   The code also forces it during an insulation test, with no alarm on the selected value.
// [RULE10] Warnings never cause fail-safe and are only reported as status information.
// [RULE11] In individual alarm mode every alarm and warning flag can be routed to the status output.
// [RULE12] A flow below its cut-off threshold is replaced by zero.
// [RULE13] Volume flow and velocity have separate cut-off thresholds, each applied only to its own value.
// [RULE14] During an insulation test measurement stops, an alarm reports it and outputs follow fail-safe.
//   The code forces fail-safe in a test only with fail-safe enabled and a mode other than status.
// [RULE15] Volume flow is corrected as factor times raw value plus offset, both programmable.
// [RULE16] For single point correction software leaves the factor at 1.0 and sets only the offset.
// [RULE17] Correction and cut-off come before limit checks, and each check runs once per update.
module pvlm_top
	import pvlm_pkg::*;
#(
	parameter int TICK_CYC = pvlm_pkg::PVLM_TICK_CYC
)(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [pvlm_pkg::PVLM_AW-1:0] paddr,
	input wire logic [pvlm_pkg::PVLM_DW-1:0] pwdata,
	output logic [pvlm_pkg::PVLM_DW-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire pvlm_pkg::pvlm_sample_t sample,
	output pvlm_pkg::pvlm_flags_t flags
);
	import pvlm_pkg::*;

	// ==============================
	// storage
	logic signed [31:0] lim_ff [PVLM_NCH][PVLM_NLIM];
	logic signed [31:0] adj_ofs_ff;
	logic signed [31:0] adj_fac_ff;
	logic signed [31:0] cut_ff [2];
	logic [31:0] ctrl_ff;
	pvlm_sample_t smp_ff;
	logic signed [31:0] pv_ff [PVLM_NCH];
	logic [2:0] ua_ff;
	logic [2:0] la_ff;
	logic [2:0] wrn_ff;
	pvlm_flags_t flags_ff;
	pvlm_state_t st_ff;
	logic [31:0] tick_cnt_ff;
	logic [31:0] prdata_ff;
	logic pready_ff;
	logic pslverr_ff;
	logic [2:0] nxt_ua;
	logic [2:0] nxt_la;
	logic [2:0] nxt_wrn;
	logic signed [63:0] prod;
	logic tick;
	logic wr_en;
	logic insul;
	logic [2:0] alm_any;

	// ==============================
	// decode helpers
	function automatic logic addr_hit(input logic [PVLM_AW-1:0] a);
		if (a < PVLM_LIM_END)
			addr_hit = (a[1:0] == 2'h0) && (a[6:5] < 2'(PVLM_NCH))
				&& (a[4:2] < 3'(PVLM_NLIM));
		else
			addr_hit = (a[1:0] == 2'h0) && (a <= PVLM_PV_CON);
	endfunction

	// zero a flow whose magnitude is under its cut-off
	function automatic logic signed [31:0] cut_off(input logic signed [31:0] v,
		input logic signed [31:0] th);
		logic signed [32:0] mag;
		mag = (v < 0) ? -33'(v) : 33'(v);
		cut_off = (mag < 33'(th)) ? 32'sh0 : v;
	endfunction

	assign wr_en = psel && penable && pready_ff && pwrite && addr_hit(paddr);
	assign insul = ctrl_ff[PVLM_C_INS];
	assign alm_any = ua_ff | la_ff;

	// ==============================
	// apb slave: zero wait state, registered answer
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h0;
		end
		else if (psel && !penable)
		begin
			pready_ff <= 1'b1;
			pslverr_ff <= !addr_hit(paddr);
			prdata_ff <= 32'h0;
			if (!pwrite && addr_hit(paddr))
			begin
				if (paddr < PVLM_LIM_END)
					prdata_ff <= lim_ff[paddr[6:5]][paddr[4:2]];
				else
					case (paddr)
						PVLM_ADJ_OFS: prdata_ff <= adj_ofs_ff;
						PVLM_ADJ_FAC: prdata_ff <= adj_fac_ff;
						PVLM_CUT_VOL: prdata_ff <= cut_ff[0];
						PVLM_CUT_VEL: prdata_ff <= cut_ff[1];
						PVLM_CTRL: prdata_ff <= ctrl_ff;
						PVLM_STAT: prdata_ff <= 32'(flags_ff);
						PVLM_PV_VOL: prdata_ff <= pv_ff[0];
						PVLM_PV_VEL: prdata_ff <= pv_ff[1];
						PVLM_PV_CON: prdata_ff <= pv_ff[2];
						default: prdata_ff <= 32'h0;
					endcase
			end
		end
		else
		begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
		end
	end

	// ==============================
	// configuration writes
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int c = 0; c < PVLM_NCH; c++)
				for (int k = 0; k < PVLM_NLIM; k++)
					lim_ff[c][k] <= 32'sh0;
			adj_ofs_ff <= 32'sh0;
			adj_fac_ff <= PVLM_FAC_ONE; // unity factor until software changes it
			cut_ff[0] <= 32'sh0;
			cut_ff[1] <= 32'sh0;
			ctrl_ff <= PVLM_CTRL_RST;
		end
		else if (wr_en)
		begin
			if (paddr < PVLM_LIM_END)
				lim_ff[paddr[6:5]][paddr[4:2]] <= pwdata; // RULE2
			else
				case (paddr)
					PVLM_ADJ_OFS: adj_ofs_ff <= pwdata; // RULE15
					PVLM_ADJ_FAC: adj_fac_ff <= pwdata; // RULE15
					PVLM_CUT_VOL: cut_ff[0] <= pwdata; // RULE13
					PVLM_CUT_VEL: cut_ff[1] <= pwdata; // RULE13
					PVLM_CTRL: ctrl_ff <= pwdata;
					default: ;
				endcase
		end
	end

	// ==============================
	// sensor capture: keep the newest sample set
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			smp_ff <= '0;
		else if (sample.valid)
			smp_ff <= sample;
	end

	// ==============================
	// 10 ms update tick
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			tick_cnt_ff <= 32'h0;
		else if (tick)
			tick_cnt_ff <= 32'h0;
		else
			tick_cnt_ff <= tick_cnt_ff + 32'h1;
	end
	assign tick = (tick_cnt_ff == 32'(TICK_CYC - 1)); // RULE1

	// ==============================
	// update sequence: correct, then compare once
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st_ff <= PVLM_ST_IDLE;
		else
			case (st_ff)
				PVLM_ST_IDLE: if (tick && !insul) st_ff <= PVLM_ST_CORR; // RULE1 RULE14
				PVLM_ST_CORR: st_ff <= PVLM_ST_COMP; // RULE17
				PVLM_ST_COMP: st_ff <= PVLM_ST_IDLE; // RULE17
				default: st_ff <= PVLM_ST_IDLE;
			endcase
	end

	assign prod = 64'(smp_ff.vol) * 64'(adj_fac_ff);

	// corrected and cut volume flow, cut velocity, conductivity passed through
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			for (int c = 0; c < PVLM_NCH; c++)
				pv_ff[c] <= 32'sh0;
		else if (st_ff == PVLM_ST_CORR)
		begin
			pv_ff[0] <= cut_off(prod[PVLM_FRAC+31:PVLM_FRAC] + adj_ofs_ff, cut_ff[0]); // RULE12 RULE13 RULE15
			pv_ff[1] <= cut_off(smp_ff.vel, cut_ff[1]); // RULE12 RULE13
			pv_ff[2] <= smp_ff.cond;
		end
	end

	// ==============================
	// limit evaluation per channel
	for (genvar c = 0; c < PVLM_NCH; c++)
	begin : g_lim
		logic signed [32:0] v;
		logic signed [32:0] ua_clr;
		logic signed [32:0] la_clr;
		assign v = 33'(pv_ff[c]);
		assign ua_clr = 33'(lim_ff[c][PVLM_LIM_UA]) - 33'(lim_ff[c][PVLM_LIM_HY]);
		assign la_clr = 33'(lim_ff[c][PVLM_LIM_LA]) + 33'(lim_ff[c][PVLM_LIM_HY]);
		always_comb
		begin
			// set above the limit, hold until below limit minus hysteresis
			if (v > 33'(lim_ff[c][PVLM_LIM_UA]))
				nxt_ua[c] = 1'b1; // RULE3
			else if (v < ua_clr)
				nxt_ua[c] = 1'b0; // RULE5 RULE7
			else
				nxt_ua[c] = ua_ff[c]; // RULE5
			if (v < 33'(lim_ff[c][PVLM_LIM_LA]))
				nxt_la[c] = 1'b1; // RULE3
			else if (v > la_clr)
				nxt_la[c] = 1'b0; // RULE6 RULE7
			else
				nxt_la[c] = la_ff[c]; // RULE6
			// a zero lower warning limit flags any negative flow
			nxt_wrn[c] = (v > 33'(lim_ff[c][PVLM_LIM_UW]))
				|| (v < 33'(lim_ff[c][PVLM_LIM_LW])); // RULE4 RULE8
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ua_ff <= 3'h0;
			la_ff <= 3'h0;
			wrn_ff <= 3'h0;
		end
		else if (st_ff == PVLM_ST_COMP)
		begin
			ua_ff <= nxt_ua; // RULE17
			la_ff <= nxt_la;
			wrn_ff <= nxt_wrn;
		end
	end

	// ==============================
	// output flags, fail-safe and status output
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			flags_ff <= '0;
		else
		begin
			flags_ff.alarm <= ua_ff | la_ff;
			flags_ff.warn <= wrn_ff; // RULE10
			flags_ff.insul_alarm <= insul; // RULE14
			// warnings take no part in fail-safe
			flags_ff.fail_safe <= (ctrl_ff[PVLM_C_MODE+:2] != 2'(PVLM_OUT_STATUS))
				&& ctrl_ff[PVLM_C_FSEN]
				&& (((ctrl_ff[PVLM_C_SEL+:2] < 2'(PVLM_NCH))
					&& alm_any[ctrl_ff[PVLM_C_SEL+:2]])
					|| insul); // RULE9 RULE10 RULE14
			flags_ff.status_out <= ctrl_ff[PVLM_C_IND]
				&& ((ctrl_ff[PVLM_C_MASK+:PVLM_MASK_W]
				& {wrn_ff, ua_ff | la_ff}) != 6'h0); // RULE11
		end
	end

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign flags = flags_ff;
endmodule // pvlm_top
`default_nettype wire

// *** test/pvlm_top_sva.sv ***
`default_nettype none
// ====
// port checker of the limit monitor
module pvlm_top_sva #(
	parameter int TICK_CYC = 20
)(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire pvlm_pkg::pvlm_flags_t flags
);
	timeunit 1ns;
	timeprecision 1ns;
	import pvlm_pkg::*;
	logic [5:0] prev_ff;
	int cnt_ff;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// cycles since the alarm or warning flags last moved, saturating
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prev_ff <= '0;
			cnt_ff <= TICK_CYC;
		end
		else
		begin
			prev_ff <= {flags.alarm, flags.warn};
			cnt_ff <= (prev_ff != {flags.alarm, flags.warn}) ? 1 :
				(cnt_ff < TICK_CYC) ? cnt_ff + 1 : cnt_ff;
		end
	end
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_access;
		psel && penable;
	endsequence
	a_setup_ready: assert property (s_setup |=> pready) else $error("no ready after setup");
	a_ready_once: assert property (pready |=> !pready) else $error("ready held on");
	a_ready_idle: assert property (!psel |=> !pready) else $error("ready without request");
	a_err_ready: assert property (pslverr |-> pready ##0 s_access) else $error("stray error");
	a_eval_rate: assert property (prev_ff != {flags.alarm, flags.warn} |-> cnt_ff >= TICK_CYC)
		else $error("flags moved twice in a period");
	a_insul_freeze: assert property (flags.insul_alarm [*4] |=> $stable(flags.alarm)
		&& $stable(flags.warn)) else $error("flags moved in test");
	a_fs_cause: assert property (flags.fail_safe |-> (|flags.alarm || flags.insul_alarm
		|| $past(|flags.alarm) || $past(flags.insul_alarm)) or ##1 flags.insul_alarm)
		else $error("fail safe without alarm");
	a_status_cause: assert property (flags.status_out |-> |{flags.alarm, flags.warn}
		|| $past(|{flags.alarm, flags.warn})) else $error("status without flag");
endmodule // pvlm_top_sva
bind pvlm_top pvlm_top_sva #(.TICK_CYC(TICK_CYC)) u_sva (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr), .flags(flags));
`default_nettype wire

// *** test/pvlm_sensor.sv ***
`default_nettype none
// ====
// sensor model: one sample set as a pulse every PER cycles
module pvlm_sensor #(
	parameter int PER = 7
)(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic signed [31:0] vol,
	input wire logic signed [31:0] vel,
	output var pvlm_pkg::pvlm_sample_t sample
);
	timeunit 1ns;
	timeprecision 1ns;
	import pvlm_pkg::*;
	int cnt_ff;
	// data lines carry an inverted pattern between pulses
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt_ff <= 0;
			sample <= '0;
		end
		else
		begin
			cnt_ff <= (cnt_ff == PER - 1) ? 0 : cnt_ff + 1;
			sample.valid <= (cnt_ff == PER - 1);
			sample.vol <= (cnt_ff == PER - 1) ? vol : ~vol;
			sample.vel <= (cnt_ff == PER - 1) ? vel : ~vel;
			sample.cond <= (cnt_ff == PER - 1) ? 32'h0 : 32'hffff_ffff;
		end
	end
endmodule // pvlm_sensor
`default_nettype wire

// *** test/pvlm_top_test.sv ***
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_fail++; \
	$display("wrong value at %0t: %h not %h", $time, (a), (b)); end end
// ====
// bench of the limit monitor
module pvlm_top_test;
	timeunit 1ns;
	timeprecision 1ns;
	import pvlm_pkg::*;
	localparam int TC = 20;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic pready, pslverr, er, ua = 1'b0, la = 1'b0;
	logic signed [31:0] vol = '0, vel = '0, v, e;
	logic signed [31:0] lim [5] = '{100, 80, 0, -100, 10};
	logic signed [31:0] seq [8] = '{150, 95, 85, 50, -5, -150, -95, -85};
	logic signed [31:0] vr [4] = '{3, -8, 10, -4};
	logic [31:0] fsc [6] = '{1, 3, 5, 7, 0, 9};
	pvlm_sample_t sample;
	pvlm_flags_t flags;
	int n_fail = 0, tests_run = 0, cyc = 0;
	pvlm_top #(.TICK_CYC(TC)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .sample(sample), .flags(flags));
	pvlm_sensor #(.PER(7)) u_sen (.pclk(pclk), .presetn(presetn), .vol(vol), .vel(vel),
		.sample(sample));
	always #50 pclk = ~pclk;
	// hang guard
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_fail++;
			stop_test();
		end
	end
	task automatic stop_test();
		$display("comparisons %0d, mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// one apb transfer; the answer is taken at the edge where pready is high
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1)
			n_fail++;
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	// present a flow value and let three update periods pass
	task automatic feed(input logic signed [31:0] x);
		vol <= x;
		repeat (3 * TC) @(posedge pclk);
	endtask
	// alarm state of the volume channel
	function automatic void step(input logic signed [31:0] x, input logic signed [31:0] hy);
		if (x > 100)
			ua = 1'b1;
		else if (x < 100 - hy)
			ua = 1'b0;
		if (x < -100)
			la = 1'b1;
		else if (x > -100 + hy)
			la = 1'b0;
	endfunction
	// flow value after the cut-off
	function automatic logic signed [31:0] cut(input logic signed [31:0] x, input int c);
		return (x < c && x > -c) ? 0 : x;
	endfunction
	// main sequence
	initial
	begin
		void'($urandom(42943));
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		xfer(1'b0, PVLM_ADJ_FAC, '0);
		`CHK(rd, PVLM_FAC_ONE)
		xfer(1'b0, PVLM_CTRL, '0);
		`CHK(rd, PVLM_CTRL_RST)
		xfer(1'b0, 8'h90, '0);
		`CHK({er, rd}, {1'b1, 32'h0})
		for (int p = 0; p < 2; p++)
		begin
			lim[4] = p ? 0 : 10;
			for (int i = 0; i < 5; i++)
				xfer(1'b1, 8'(i * 4), lim[i]);
			xfer(1'b0, 8'h10, '0);
			`CHK(rd, lim[4])
			for (int k = 0; k < 18; k++)
			begin
				v = (k < 8) ? seq[k] : int'($urandom_range(400)) - 200;
				feed(v);
				step(v, lim[4]);
				`CHK(flags.alarm[0], ua | la)
				`CHK(flags.warn[0], v > 80 || v < 0)
			end
			$display("limit pass %0d done", p);
		end
		feed(150);
		for (int m = 0; m < 6; m++)
		begin
			xfer(1'b1, PVLM_CTRL, fsc[m]);
			repeat (5) @(posedge pclk);
			`CHK(flags.fail_safe, m < 3)
		end
		xfer(1'b1, PVLM_CTRL, 32'h1);
		feed(90);
		xfer(1'b1, 8'h20, 32'hffff_ffff);
		feed(90);
		`CHK({flags.alarm[1:0], flags.fail_safe}, 3'b100)
		`CHK({flags.warn[0], flags.fail_safe}, 2'b10)
		xfer(1'b1, PVLM_CTRL, 32'h820);
		repeat (5) @(posedge pclk);
		`CHK(flags.status_out, 1'b1)
		xfer(1'b1, PVLM_CTRL, 32'h120);
		repeat (5) @(posedge pclk);
		`CHK(flags.status_out, 1'b0)
		$display("output test done");
		xfer(1'b1, PVLM_CUT_VOL, 32'h14);
		xfer(1'b1, PVLM_CUT_VEL, 32'h5);
		for (int p = 0; p < 2; p++)
		begin
			xfer(1'b1, PVLM_ADJ_FAC, p ? PVLM_FAC_ONE : 32'h0002_0000);
			xfer(1'b1, PVLM_ADJ_OFS, p ? 25 : 7);
			for (int k = 0; k < 4; k++)
			begin
				v = (k < 3) ? seq[k + 2] : int'($urandom_range(2000)) - 1000;
				vel <= vr[k];
				feed(v);
				e = cut(v * (p ? 1 : 2) + (p ? 25 : 7), 20);
				xfer(1'b0, PVLM_PV_VOL, '0);
				`CHK(rd, e)
				xfer(1'b0, PVLM_PV_VEL, '0);
				`CHK(rd, cut(vr[k], 5))
			end
		end
		$display("correction test done");
		xfer(1'b1, PVLM_CTRL, 32'h41);
		feed(-500);
		`CHK({flags.insul_alarm, flags.fail_safe}, 2'b11)
		xfer(1'b0, PVLM_PV_VOL, '0);
		`CHK(rd, e)
		$display("insulation test done");
		stop_test();
	end
endmodule // pvlm_top_test
`default_nettype wire
